// ==== logic/tcp_deadband.sv ====
// Deadband generator for true and complementary PWM outputs.
// Assumes raw PWM and kill on the same clock.
`timescale 1ns/100ps
module tcp_deadband #(
   parameter int DB_W = 8
) (
   input  wire logic            clk,
   input  wire logic            rst,
   input  wire logic            raw,
   input  wire logic            kill,
   input  wire logic            cpl_en,
   input  wire logic [DB_W-1:0] dead,
   output logic                 out_p,
   output logic                 out_n
);
   logic            raw_q;
   logic [DB_W-1:0] gap;
   logic            settled;

   // Edge cycle counts as the first gap cycle, so the delay is exactly dead
   assign settled = (raw != raw_q) ? (dead == '0) : (gap == '0);

   // Gap counter restarts on each raw edge
   always_ff @(posedge clk) begin
      if (rst) begin
         raw_q <= 1'b0;
         gap   <= '0;
      end else begin
         raw_q <= raw;
         if (raw != raw_q) begin
            gap <= (dead == '0) ? '0 : dead - 1'b1;
         end else if (gap != '0) begin
            gap <= gap - 1'b1;
         end
      end
   end

   // Outputs rise only after the gap; kill forces inactive
   always_ff @(posedge clk) begin
      if (rst) begin
         out_p <= 1'b0;
         out_n <= 1'b0;
      end else if (kill) begin
         out_p <= 1'b0;
         out_n <= 1'b0;
      end else begin
         out_p <= raw & settled;
         out_n <= cpl_en & ~raw & settled;
      end
   end
endmodule : tcp_deadband

// ==== logic/tcp_pkg.sv ====
// Shared constants for the 16-bit timer, counter and PWM unit.
// Assumes an APB slave with 32-bit data and byte addresses.
package tcp_pkg;
   // Register byte offsets
   localparam logic [7:0] TCP_ADDR_CTRL     = 8'h00;
   localparam logic [7:0] TCP_ADDR_PERIOD   = 8'h04;
   localparam logic [7:0] TCP_ADDR_COMPARE  = 8'h08;
   localparam logic [7:0] TCP_ADDR_DEADBAND = 8'h0C;
   localparam logic [7:0] TCP_ADDR_COUNT    = 8'h10;
   localparam logic [7:0] TCP_ADDR_CAPTURE  = 8'h14;
   localparam logic [7:0] TCP_ADDR_STATUS   = 8'h18;
   localparam logic [7:0] TCP_ADDR_CMD      = 8'h1C;

   // Control register fields
   localparam int TCP_CTRL_MODE_LSB = 0;
   localparam int TCP_CTRL_REL_LSB  = 2;
   localparam int TCP_CTRL_SEL_LSB  = 5;
   localparam int TCP_CTRL_CPL_BIT  = 7;
   localparam int TCP_CTRL_CAP_BIT  = 8;
   localparam int TCP_CTRL_WIDTH    = 9;

   // Status register fields
   localparam int TCP_STAT_RUN_BIT  = 0;
   localparam int TCP_STAT_CAP_BIT  = 1;
   localparam int TCP_STAT_KILL_BIT = 2;
   localparam int TCP_STAT_EN_BIT   = 3;

   // Command register fields
   localparam int TCP_CMD_START_BIT = 0;
   localparam int TCP_CMD_STOP_BIT  = 1;

   // Reset values
   localparam logic [15:0] TCP_PERIOD_RST   = 16'hFFFF;
   localparam logic [15:0] TCP_COMPARE_RST  = 16'h8000;
   localparam logic [7:0]  TCP_DEADBAND_RST = 8'h00;
   localparam logic [8:0]  TCP_CTRL_RST     = 9'h000;

   // Run modes
   typedef enum logic [1:0] {
      TCP_MODE_FREE   = 2'h0,
      TCP_MODE_ONE    = 2'h1,
      TCP_MODE_GATED  = 2'h2,
      TCP_MODE_RSVD   = 2'h3
   } tcp_mode_t;

   // Compare relations
   typedef enum logic [2:0] {
      TCP_REL_LT  = 3'h0,
      TCP_REL_LTE = 3'h1,
      TCP_REL_EQ  = 3'h2,
      TCP_REL_GTE = 3'h3,
      TCP_REL_GT  = 3'h4
   } tcp_rel_t;
endpackage : tcp_pkg

// ==== logic/tcp_sync.sv ====
// Three-stage synchroniser for a routed input with edge pulse.
// Assumes the input may change at any time relative to clk.
`timescale 1ns/100ps
module tcp_sync (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic din,
   output logic      level,
   output logic      rise
);
   logic s1;
   logic s2;
   logic s3;

   // Shift chain, first stage read only by the second
   always_ff @(posedge clk) begin
      if (rst) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
      end else begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // Level follows once stages two and three agree
   always_ff @(posedge clk) begin
      if (rst) begin
         level <= 1'b0;
         rise  <= 1'b0;
      end else begin
         rise <= 1'b0;
         if (s2 == s3) begin
            level <= s3;
            rise  <= s3 & ~level;   // One cycle per event
         end
      end
   end
endmodule : tcp_sync

// ==== logic/tcp_timer.sv ====
// Top of the 16-bit down-counting timer, counter and PWM unit.
// Assumes an APB master and src_tick on clk, and the other routed inputs from any clock domain.
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/100ps

module tcp_timer
   import tcp_pkg::*;
#(
   parameter int CNT_W = 16,
   parameter int DB_W  = 8,
   parameter int N_SRC = 4
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [7:0]       paddr,
   input  wire logic [31:0]      pwdata,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   input  wire logic [N_SRC-1:0] src_tick,
   input  wire logic             reset_in,
   input  wire logic             capture_in,
   input  wire logic             enable_in,
   input  wire logic             kill_in,
   output logic                  cmp_out,
   output logic                  cmp_n_out,
   output logic                  tc_out
);
   logic [TCP_CTRL_WIDTH-1:0] ctrl;
   logic [CNT_W-1:0]          period;
   logic [CNT_W-1:0]          compare;
   logic [DB_W-1:0]           deadband;
   logic [CNT_W-1:0]          count;
   logic [CNT_W-1:0]          capture;
   logic                      running;
   logic                      cap_full;
   logic                      rst_lvl;
   logic                      rst_evt;
   logic                      cap_lvl;
   logic                      cap_evt;
   logic                      en_lvl;
   logic                      kill_lvl;
   logic                      wr_en;
   logic                      rd_en;
   logic                      start_cmd;
   logic                      stop_cmd;
   logic                      tick;
   logic                      step;
   logic                      at_zero;
   logic                      pwm_raw;
   logic                      mapped;
   tcp_mode_t                 mode;
   tcp_rel_t                  rel;
   logic [1:0]                src_sel;

   // Compare relation between count and compare value
   function automatic logic rel_true(input tcp_rel_t r, input logic [CNT_W-1:0] a,
                                     input logic [CNT_W-1:0] b);
      logic res;
      res = 1'b0;
      unique case (r)
         TCP_REL_LT:  res = (a <  b);
         TCP_REL_LTE: res = (a <= b);
         TCP_REL_EQ:  res = (a == b);
         TCP_REL_GTE: res = (a >= b);
         TCP_REL_GT:  res = (a >  b);
         default:     res = 1'b0;
      endcase
      return res;
   endfunction : rel_true

   // Address decode for the register map
   function automatic logic addr_ok(input logic [7:0] a);
      return (a == TCP_ADDR_CTRL)    || (a == TCP_ADDR_PERIOD)  ||
             (a == TCP_ADDR_COMPARE) || (a == TCP_ADDR_DEADBAND) ||
             (a == TCP_ADDR_COUNT)   || (a == TCP_ADDR_CAPTURE) ||
             (a == TCP_ADDR_STATUS)  || (a == TCP_ADDR_CMD);
   endfunction : addr_ok

   // Routed inputs other than src_tick through three-stage synchronisers
   tcp_sync u_sync_rst (
      .clk   (clk),
      .rst   (rst),
      .din   (reset_in),
      .level (rst_lvl),
      .rise  (rst_evt)
   );
   tcp_sync u_sync_cap (
      .clk   (clk),
      .rst   (rst),
      .din   (capture_in),
      .level (cap_lvl),
      .rise  (cap_evt)
   );
   tcp_sync u_sync_en (
      .clk   (clk),
      .rst   (rst),
      .din   (enable_in),
      .level (en_lvl),
      .rise  ()
   );
   tcp_sync u_sync_kill (
      .clk   (clk),
      .rst   (rst),
      .din   (kill_in),
      .level (kill_lvl),
      .rise  ()
   );

   // Control field extraction
   assign mode    = tcp_mode_t'(ctrl[TCP_CTRL_MODE_LSB +: 2]);
   assign rel     = tcp_rel_t'(ctrl[TCP_CTRL_REL_LSB +: 3]);
   assign src_sel = ctrl[TCP_CTRL_SEL_LSB +: 2];

   // APB strobes; slave always ready in the access phase
   assign pready  = 1'b1;
   assign mapped  = addr_ok(paddr);
   assign pslverr = psel & penable & ~mapped;
   assign wr_en   = psel & penable & pwrite & mapped;
   assign rd_en   = psel & penable & ~pwrite & mapped;
   assign start_cmd = wr_en & (paddr == TCP_ADDR_CMD) & pwdata[TCP_CMD_START_BIT];
   assign stop_cmd  = wr_en & (paddr == TCP_ADDR_CMD) & pwdata[TCP_CMD_STOP_BIT];

   // Writable configuration registers
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl     <= TCP_CTRL_RST;
         period   <= TCP_PERIOD_RST;
         compare  <= TCP_COMPARE_RST;
         deadband <= TCP_DEADBAND_RST;
      end else if (wr_en) begin
         unique case (paddr)
            TCP_ADDR_CTRL:     ctrl     <= pwdata[TCP_CTRL_WIDTH-1:0];
            TCP_ADDR_PERIOD:   period   <= pwdata[CNT_W-1:0];
            TCP_ADDR_COMPARE:  compare  <= pwdata[CNT_W-1:0];
            TCP_ADDR_DEADBAND: deadband <= pwdata[DB_W-1:0];
            default: ;
         endcase
      end
   end

   // Count tick source selection, zero picks every clock
   assign tick = (src_sel == 2'h0) ? 1'b1 : src_tick[src_sel];

   // Step qualifies tick by run state and gating mode
   assign at_zero = (count == '0);
   assign step = running & tick &
                 ((mode != TCP_MODE_GATED) | en_lvl);

   // Down counter with period reload
   always_ff @(posedge clk) begin
      if (rst) begin
         count <= TCP_PERIOD_RST;
      end else if (start_cmd || rst_evt) begin
         count <= period;
      end else if (step) begin
         if (at_zero) begin
            count <= period;
         end else begin
            count <= count - 1'b1;
         end
      end
   end

   // Run state; one-shot halts at terminal count
   always_ff @(posedge clk) begin
      if (rst) begin
         running <= 1'b0;
      end else if (start_cmd || rst_evt) begin
         running <= 1'b1;
      end else if (stop_cmd) begin
         running <= 1'b0;
      end else if (step && at_zero && mode == TCP_MODE_ONE) begin
         running <= 1'b0;
      end
   end

   // Terminal-count pulse, one clock per reach of zero
   always_ff @(posedge clk) begin
      if (rst) begin
         tc_out <= 1'b0;
      end else begin
         tc_out <= step & at_zero;
      end
   end

   // Capture register, full width, only in capture mode
   always_ff @(posedge clk) begin
      if (rst) begin
         capture <= '0;
      end else if (cap_evt && ctrl[TCP_CTRL_CAP_BIT]) begin
         capture <= count;
      end
   end

   // Capture-full flag; new capture wins over read clear
   always_ff @(posedge clk) begin
      if (rst) begin
         cap_full <= 1'b0;
      end else if (cap_evt && ctrl[TCP_CTRL_CAP_BIT]) begin
         cap_full <= 1'b1;
      end else if (rd_en && paddr == TCP_ADDR_CAPTURE) begin
         cap_full <= 1'b0;
      end
   end

   // Comparator feeding the deadband stage
   assign pwm_raw = running & rel_true(rel, count, compare);

   tcp_deadband #(
      .DB_W (DB_W)
   ) u_deadband (
      .clk    (clk),
      .rst    (rst),
      .raw    (pwm_raw),
      .kill   (kill_lvl),
      .cpl_en (ctrl[TCP_CTRL_CPL_BIT]),
      .dead   (deadband),
      .out_p  (cmp_out),
      .out_n  (cmp_n_out)
   );

   // Read data mux, registered in the setup phase
   always_ff @(posedge clk) begin
      if (rst) begin
         prdata <= '0;
      end else if (psel && !penable && !pwrite) begin
         prdata <= '0;
         unique case (paddr)
            TCP_ADDR_CTRL:     prdata[TCP_CTRL_WIDTH-1:0] <= ctrl;
            TCP_ADDR_PERIOD:   prdata[CNT_W-1:0] <= period;
            TCP_ADDR_COMPARE:  prdata[CNT_W-1:0] <= compare;
            TCP_ADDR_DEADBAND: prdata[DB_W-1:0]  <= deadband;
            TCP_ADDR_COUNT:    prdata[CNT_W-1:0] <= count;
            TCP_ADDR_CAPTURE:  prdata[CNT_W-1:0] <= capture;
            TCP_ADDR_STATUS: begin
               prdata[TCP_STAT_RUN_BIT]  <= running;
               prdata[TCP_STAT_CAP_BIT]  <= cap_full;
               prdata[TCP_STAT_KILL_BIT] <= kill_lvl;
               prdata[TCP_STAT_EN_BIT]   <= en_lvl;
            end
            default: ;
         endcase
      end
   end
endmodule : tcp_timer

// ==== verif/tcp_far_model.sv ====
// Model of the routed logic feeding the timer.
// Assumes one-cycle requests from the bench.
`timescale 1ns/100ps
module tcp_far_model (
   input  wire logic  clk,
   input  wire logic  rst_req,
   input  wire logic  cap_req,
   output logic [3:0] src_tick,
   output logic       reset_in,
   output logic       capture_in
);
   logic [2:0] div = 3'h0;
   logic [2:0] rlen = 3'h0;
   logic [2:0] clen = 3'h0;
   // Ticks every 2nd, 4th and 8th clock
   always_ff @(posedge clk) begin
      div <= div + 3'h1;
   end
   assign src_tick = {div == 3'h7, div[1:0] == 2'h3, div[0], 1'b0};
   // Requests widened to 4 cycles
   always_ff @(posedge clk) begin
      rlen <= rst_req ? 3'h4 : rlen - 3'(rlen != 3'h0);
      clen <= cap_req ? 3'h4 : clen - 3'(clen != 3'h0);
   end
   assign reset_in = rlen != 3'h0;
   assign capture_in = clen != 3'h0;
endmodule : tcp_far_model

// ==== verif/tcp_timer_properties.sv ====
// Port assertions for the timer unit.
// Assumes binding into tcp_timer, one clock.
`timescale 1ns/100ps
module tcp_timer_properties (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        kill_in,
   input wire logic        cmp_out,
   input wire logic        cmp_n_out,
   input wire logic        tc_out
);
   // One clock domain
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   // Bus answers
   a_ready_always: assert property (psel |-> pready)
      else $error("pready low");
   a_err_unmapped: assert property (psel && penable && paddr > 8'h1C |-> pslverr)
      else $error("no error on unmapped place");
   a_ok_mapped: assert property (psel && penable && paddr < 8'h1C && paddr[1:0] == 2'h0
      |-> !pslverr)
      else $error("error on mapped place");
   a_err_data: assert property (pslverr && !pwrite |-> prdata == 32'h0)
      else $error("data on refused read");
   // Outputs
   a_tc_single: assert property (tc_out |=> !tc_out)
      else $error("terminal pulse too long");
   a_no_overlap: assert property (!(cmp_out && cmp_n_out))
      else $error("both outputs active");
   a_kill_quiet: assert property (kill_in [*8] |-> !cmp_out && !cmp_n_out)
      else $error("output active under kill");
   a_reset_quiet: assert property ($fell(rst) |-> !tc_out && !cmp_out && !cmp_n_out)
      else $error("output active after reset");
endmodule : tcp_timer_properties

bind tcp_timer tcp_timer_properties u_props (.clk, .rst, .psel, .penable, .pwrite,
   .paddr, .prdata, .pready, .pslverr, .kill_in, .cmp_out, .cmp_n_out, .tc_out);

// ==== verif/testbench.sv ====
// Self-checking bench for the timer unit.
// Assumes the routed-logic model tcp_far_model.
`timescale 1ns/100ps
module testbench
   import tcp_pkg::*;
;
   logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        enable_in = 1'b0, kill_in = 1'b0, rst_req = 1'b0, cap_req = 1'b0;
   logic        pready, pslverr, rerr, reset_in, capture_in, cmp_out, cmp_n_out, tc_out;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdata;
   logic [3:0]  src_tick;
   int          n_errors = 0, checked = 0, seed = 32'haefe, p, c, g, h, hn;

   // Clock
   always #2.5 clk = ~clk;

   tcp_timer u_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .src_tick, .reset_in, .capture_in, .enable_in, .kill_in,
      .cmp_out, .cmp_n_out, .tc_out);
   tcp_far_model u_far (.clk, .rst_req, .cap_req, .src_tick, .reset_in, .capture_in);

   task automatic report_and_stop;
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop

   task automatic check(input string w, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", w, exp, seen);
      end
   endtask : check

   task automatic stall(input string w);
      check(w, 32'h0, 32'h1);
      report_and_stop;
   endtask : stall

   // One bus transfer, waiting on pready
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n == 20)
         stall("pready");
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string w);
      apb(1'b0, a, 32'h0);
      check(w, rdata, e);
   endtask : rd

   task automatic run(input logic [31:0] ctl, pr, cm);
      apb(1'b1, TCP_ADDR_CTRL, ctl);
      apb(1'b1, TCP_ADDR_PERIOD, pr);
      apb(1'b1, TCP_ADDR_COMPARE, cm);
      apb(1'b1, TCP_ADDR_CMD, 32'h1);
   endtask : run

   // Cycles between two terminal pulses
   task automatic gap;
      int n;
      repeat (2) begin
         n = 0;
         do begin
            @(posedge clk);
            n++;
         end while (tc_out !== 1'b1 && n < 3000);
         if (n == 3000)
            stall("tc");
      end
      g = n;
   endtask : gap

   task automatic highs(input int w);
      h = 0;
      hn = 0;
      repeat (w) begin
         @(posedge clk);
         h += int'(cmp_out);
         hn += int'(cmp_n_out);
      end
   endtask : highs

   task automatic poke(input logic cap);
      cap_req <= cap;
      rst_req <= !cap;
      @(posedge clk);
      cap_req <= 1'b0;
      rst_req <= 1'b0;
      repeat (10) @(posedge clk);
   endtask : poke

   // Counts in one period that meet the relation
   function automatic int n_true(int pr, int cm, int r);
      n_true = 0;
      for (int v = 0; v <= pr; v++)
         n_true += int'(r == 0 ? v < cm : r == 1 ? v <= cm : r == 2 ? v == cm
            : r == 3 ? v >= cm : v > cm);
   endfunction : n_true

   // Main sequence
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd(TCP_ADDR_PERIOD, 32'hFFFF, "period");
      rd(TCP_ADDR_COMPARE, 32'h8000, "compare");
      rd(TCP_ADDR_COUNT, 32'hFFFF, "count");
      rd(TCP_ADDR_STATUS, 32'h0, "status");
      rd(8'h20, 32'h0, "unmapped");
      check("slverr", rerr, 32'h1);
      // Every relation, random period and threshold
      for (int r = 0; r < 5; r++) begin
         p = 8 + {$random(seed)} % 24;
         c = {$random(seed)} % (p + 1);
         run(r << TCP_CTRL_REL_LSB, p, c);
         gap;
         check("reload", g, p + 1);
         highs(p + 1);
         check("cmp", h, n_true(p, c, r));
         check("cmp_n", hn, 0);
      end
      // Complement with two-cycle deadband
      apb(1'b1, TCP_ADDR_DEADBAND, 32'h2);
      run(32'h80, 15, 8);
      gap;
      highs(16);
      check("db_p", h, 6);
      check("db_n", hn, 6);
      kill_in <= 1'b1;
      repeat (10) @(posedge clk);
      highs(32);
      check("kill", h + hn, 0);
      rd(TCP_ADDR_STATUS, 32'h5, "st_kill");
      kill_in <= 1'b0;
      // Slower tick sources
      for (int s = 1; s < 4; s++) begin
         run(s << TCP_CTRL_SEL_LSB, 9, 4);
         gap;
         check("tick", g, 10 << s);
      end
      // Gated counting
      run(32'h2, 500, 0);
      rd(TCP_ADDR_COUNT, 32'd500, "hold");
      enable_in <= 1'b1;
      repeat (8) @(posedge clk);
      apb(1'b0, TCP_ADDR_COUNT, 32'h0);
      c = rdata;
      rd(TCP_ADDR_COUNT, c - 3, "down");
      // One-shot then stop
      run(32'h1, 10, 0);
      h = 0;
      repeat (60) begin
         @(posedge clk);
         h += int'(tc_out);
      end
      check("oneshot", h, 1);
      rd(TCP_ADDR_STATUS, 32'h8, "st_stop");
      // Capture off, then on
      run(32'h0, 200, 0);
      poke(1'b1);
      rd(TCP_ADDR_STATUS, 32'h9, "no_cap");
      run(32'h100, 200, 0);
      poke(1'b1);
      rd(TCP_ADDR_STATUS, 32'hB, "cap");
      apb(1'b0, TCP_ADDR_CAPTURE, 32'h0);
      check("cap_rng", rdata <= 32'd200, 32'h1);
      rd(TCP_ADDR_STATUS, 32'h9, "cap_clr");
      // Routed restart
      repeat (150) @(posedge clk);
      poke(1'b0);
      apb(1'b0, TCP_ADDR_COUNT, 32'h0);
      check("restart", rdata > 32'd180, 32'h1);
      apb(1'b1, TCP_ADDR_CMD, 32'h2);
      rd(TCP_ADDR_STATUS, 32'h8, "halt");
      report_and_stop;
   end
endmodule : testbench
